// *** rtl/sinc3_pkg.sv ***
// Constants, lookup tables and types for the fast settling sinc3 decimation path.
// What this block does
// - Fast mode rate: fclk/((3+avg-1)*1024*word).
// - Filter word is unsigned ten-bit value.
// - Average select zero turns fast mode off.
// - Fast mode: settled result one output period after start.
// - Channel change adds no extra conversion delay.
// - Input steps never restart the filter.
// - Mid-conversion step gives one unsettled result, two with chop.
// - Sinc first notch at fclk/(1024*word).
// - Postfilter notches at sinc notch over avg.
// - Word 6, avg 16: 44.44 Hz output.
// - Word 5, avg 16: 53.33 Hz output.
// - Word 30, avg 16: 8.9 Hz output.
// - Word 96 with 60 Hz notch: 2.78 Hz.
// - Chop swaps input polarity, averages conversions.
// - Chop keeps rate, settling becomes two periods.
// - Chop sinc4 example: 23.75 ms, 47.5 ms.
// - Zero latency throughput equals output data rate.
// - Postfilter averages by 2, 8 or 16.
package sinc3_pkg;

    // ----------------------------------------------------------------
    // Clocking
    // ----------------------------------------------------------------
    localparam int CLK_HZ        = 200_000_000;
    localparam int MCLK_HZ       = 4_920_000;
    localparam int MCLK_DIV      = CLK_HZ / MCLK_HZ;
    localparam int MOD_PRESCALE  = 16;
    localparam int NOTCH_SCALE   = 1024;
    localparam int DEC_PER_WORD  = NOTCH_SCALE / MOD_PRESCALE;
    localparam int SINC_ORDER    = 3;

    // ----------------------------------------------------------------
    // Widths and field layout
    // ----------------------------------------------------------------
    localparam int FW_W     = 10;
    localparam int FW_MSB   = 9;
    localparam int FW_LSB   = 0;
    localparam int CNT_W    = 16;
    localparam int IDX_W    = 5;
    localparam int ACC_W    = 50;
    localparam int SUM_W    = ACC_W + 5;
    localparam int RES_W    = ACC_W;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [7:0]       MCLK_CNT_RST = 8'h00;
    localparam logic [3:0]       PRE_CNT_RST  = 4'h0;
    localparam logic [CNT_W-1:0] SAMP_RST     = 16'h0000;
    localparam logic [IDX_W-1:0] IDX_RST      = 5'h00;
    localparam logic [1:0]       FRAMES_RST   = 2'h0;

    // ----------------------------------------------------------------
    // Averaging lookup, indexed by the two select bits
    // ----------------------------------------------------------------
    localparam logic [IDX_W-1:0] AVG_FACTOR [0:3] = '{5'h00, 5'h02, 5'h08, 5'h10};
    localparam logic [2:0]       AVG_SHIFT  [0:3] = '{3'h0, 3'h1, 3'h3, 3'h4};
    localparam logic [1:0]       SETTLE_PLAIN     = 2'h1;
    localparam logic [1:0]       SETTLE_CHOP      = 2'h2;

    typedef logic signed [ACC_W-1:0] acc_t;
    typedef logic signed [SUM_W-1:0] sum_t;

endpackage

// *** rtl/stage_if.sv ***
// Stream link between adjacent integrator or comb stages.
`timescale 1ns/1ps
interface stage_if;
    logic                 en;
    sinc3_pkg::acc_t      data;

    modport src (input en, output data);
    modport rcv (input en, input data);
endinterface

// *** rtl/sinc_integrator.sv ***
// One integrator stage of the sinc3 decimator, wrapping two's complement.
`timescale 1ns/1ps
module sinc_integrator (
    input  wire logic clk,
    input  wire logic rst,
    stage_if.rcv      up,
    stage_if.src      dn
);
    always_ff @(posedge clk) begin
        if (rst) begin
            dn.data <= '0;
        end else if (up.en) begin
            dn.data <= dn.data + up.data;
        end
    end
endmodule // sinc_integrator

// *** rtl/sinc_comb.sv ***
// One comb stage of the sinc3 decimator, run at the decimated rate.
`timescale 1ns/1ps
module sinc_comb (
    input  wire logic clk,
    input  wire logic rst,
    stage_if.rcv      up,
    stage_if.src      dn
);
    sinc3_pkg::acc_t dly_q;

    // The difference is not registered, so a chain of combs adds no decimated latency to the window.
    assign dn.data = up.data - dly_q;

    always_ff @(posedge clk) begin
        if (rst) begin
            dly_q <= '0;
        end else if (up.en) begin
            dly_q <= up.data;
        end
    end
endmodule // sinc_comb

// *** rtl/fast_settle_sinc3_postfilter.sv ***
// Sinc3 decimator with averaging postfilter, chop and zero-latency framing.
`timescale 1ns/1ps
module fast_settle_sinc3_postfilter (
    input  wire logic                         clk,
    input  wire logic                         rst,
    input  wire logic                         mod_bit,
    input  wire logic [sinc3_pkg::FW_W-1:0]   filter_word,
    input  wire logic                         average_select_hi,
    input  wire logic                         average_select_lo,
    input  wire logic                         notch_60hz_enable,
    input  wire logic                         chop_enable,
    input  wire logic                         channel_change,
    input  wire logic                         input_step,
    output logic signed [sinc3_pkg::RES_W-1:0] result,
    output logic                              result_valid,
    output logic                              result_settled,
    output logic                              chop_invert,
    output logic                              fast_mode,
    output logic [1:0]                        settling_time
);

    // ----------------------------------------------------------------
    // Master clock and modulator sample enables
    // ----------------------------------------------------------------
    logic [7:0]  mclk_cnt_q;
    logic [3:0]  pre_cnt_q;
    logic        mclk_en;
    logic        mod_en;

    assign mclk_en = (mclk_cnt_q == 8'(sinc3_pkg::MCLK_DIV - 1));
    assign mod_en  = mclk_en && (pre_cnt_q == 4'(sinc3_pkg::MOD_PRESCALE - 1));

    always_ff @(posedge clk) begin
        if (rst) begin
            mclk_cnt_q <= sinc3_pkg::MCLK_CNT_RST;
        end else if (mclk_en) begin
            mclk_cnt_q <= sinc3_pkg::MCLK_CNT_RST;
        end else begin
            mclk_cnt_q <= mclk_cnt_q + 8'h01;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            pre_cnt_q <= sinc3_pkg::PRE_CNT_RST;
        end else if (mclk_en) begin
            pre_cnt_q <= pre_cnt_q + 4'h1;
        end
    end

    // ----------------------------------------------------------------
    // Modulator bit synchroniser and sample mapping
    // ----------------------------------------------------------------
    logic sync1_q;
    logic sync2_q;

    always_ff @(posedge clk) begin
        if (rst) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
        end else begin
            sync1_q <= mod_bit;
            sync2_q <= sync1_q;
        end
    end

    // ----------------------------------------------------------------
    // Configuration decode
    // ----------------------------------------------------------------
    logic [1:0]                 avg_code;
    logic [sinc3_pkg::IDX_W-1:0] frame_len;
    logic [sinc3_pkg::CNT_W-1:0] dec_len;
    logic [sinc3_pkg::FW_W-1:0]  word_eff;
    logic [sinc3_pkg::FW_W+3:0]  cfg_now;
    logic [sinc3_pkg::FW_W+3:0]  cfg_q;
    logic                        restart;

    assign avg_code  = {average_select_hi, average_select_lo};
    assign fast_mode = (avg_code != 2'b00);
    // A zero word would stall the decimator, so it runs as a word of one.
    assign word_eff  = (filter_word == '0) ? 10'h001 : filter_word;
    // Decimation of 1024 master clocks per word unit sets the first notch.
    assign dec_len   = sinc3_pkg::CNT_W'(word_eff * sinc3_pkg::DEC_PER_WORD);
    // Frame spans (3 + avg - 1) sinc periods in fast mode.
    assign frame_len = fast_mode
                     ? sinc3_pkg::IDX_W'(sinc3_pkg::SINC_ORDER - 1) + sinc3_pkg::AVG_FACTOR[avg_code]
                     : sinc3_pkg::IDX_W'(sinc3_pkg::SINC_ORDER);
    assign cfg_now   = {filter_word, avg_code, chop_enable, notch_60hz_enable};
    // Only a channel change or a new setup restarts framing, never an input step.
    assign restart   = channel_change || (cfg_now != cfg_q);

    always_ff @(posedge clk) begin
        if (rst) begin
            cfg_q <= '0;
        end else begin
            cfg_q <= cfg_now;
        end
    end

    // ----------------------------------------------------------------
    // Decimation counter
    // ----------------------------------------------------------------
    logic [sinc3_pkg::CNT_W-1:0] samp_cnt_q;
    logic                        dec_en;
    logic                        sinc_vld_q;

    assign dec_en = mod_en && (samp_cnt_q >= dec_len - 16'h0001);

    always_ff @(posedge clk) begin
        if (rst || restart) begin
            samp_cnt_q <= sinc3_pkg::SAMP_RST;
        end else if (dec_en) begin
            samp_cnt_q <= sinc3_pkg::SAMP_RST;
        end else if (mod_en) begin
            samp_cnt_q <= samp_cnt_q + 16'h0001;
        end
    end

    always_ff @(posedge clk) begin
        if (rst || restart) begin
            sinc_vld_q <= 1'b0;
        end else begin
            sinc_vld_q <= dec_en;
        end
    end

    // ----------------------------------------------------------------
    // Sinc3 integrator and comb chains
    // ----------------------------------------------------------------
    stage_if ig [0:sinc3_pkg::SINC_ORDER] ();
    stage_if cg [0:sinc3_pkg::SINC_ORDER] ();

    assign ig[0].data = sync2_q ? sinc3_pkg::acc_t'(1) : -sinc3_pkg::acc_t'(1);
    assign cg[0].data = ig[sinc3_pkg::SINC_ORDER].data;

    genvar g;
    generate
        for (g = 0; g <= sinc3_pkg::SINC_ORDER; g++) begin : g_en
            assign ig[g].en = mod_en;
            // Combs load a cycle late, so they see the integrators after the decimation sample.
            assign cg[g].en = sinc_vld_q;
        end
        for (g = 0; g < sinc3_pkg::SINC_ORDER; g++) begin : g_stage
            // A restart empties both chains, so the first frame holds only samples taken after it.
            sinc_integrator u_int (
                .clk (clk),
                .rst (rst || restart),
                .up  (ig[g]),
                .dn  (ig[g+1])
            );
            sinc_comb u_comb (
                .clk (clk),
                .rst (rst || restart),
                .up  (cg[g]),
                .dn  (cg[g+1])
            );
        end
    endgenerate

    // ----------------------------------------------------------------
    // Postfilter framing and averaging
    // ----------------------------------------------------------------
    logic [sinc3_pkg::IDX_W-1:0] idx_q;
    logic [sinc3_pkg::IDX_W-1:0] idx_n;
    sinc3_pkg::acc_t             sinc_now;
    sinc3_pkg::acc_t             prev_sinc_q;
    sinc3_pkg::acc_t             post_in;
    sinc3_pkg::sum_t             acc_q;
    sinc3_pkg::sum_t             acc_n;
    logic                        in_window;
    logic                        first_in_window;
    logic                        frame_end;

    assign sinc_now        = cg[sinc3_pkg::SINC_ORDER].data;
    assign idx_n           = idx_q + 5'h01;
    assign in_window       = sinc_vld_q && (idx_n >= 5'(sinc3_pkg::SINC_ORDER));
    assign first_in_window = (idx_n == 5'(sinc3_pkg::SINC_ORDER));
    // One result per completed group of averaged sinc outputs.
    assign frame_end       = sinc_vld_q && (idx_n == frame_len);

    // The optional 60 Hz term pairs each sinc output but the first of a frame with its predecessor; the first is paired with itself.
    always_comb begin
        sinc3_pkg::acc_t pair;
        pair = first_in_window ? sinc_now : prev_sinc_q;
        if (notch_60hz_enable) begin
            post_in = sinc3_pkg::acc_t'((sinc3_pkg::sum_t'(sinc_now) + sinc3_pkg::sum_t'(pair)) >>> 1);
        end else begin
            post_in = sinc_now;
        end
    end

    // Outputs past the first full sinc window are summed, which places notches at the notch over avg.
    assign acc_n = (first_in_window ? '0 : acc_q) + sinc3_pkg::sum_t'(post_in);

    always_ff @(posedge clk) begin
        if (rst || restart) begin
            idx_q <= sinc3_pkg::IDX_RST;
        end else if (frame_end) begin
            idx_q <= fast_mode ? sinc3_pkg::IDX_RST : 5'(sinc3_pkg::SINC_ORDER - 1);
        end else if (sinc_vld_q) begin
            idx_q <= idx_n;
        end
    end

    always_ff @(posedge clk) begin
        if (rst || restart) begin
            acc_q <= '0;
        end else if (in_window) begin
            acc_q <= acc_n;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            prev_sinc_q <= '0;
        end else if (sinc_vld_q) begin
            prev_sinc_q <= sinc_now;
        end
    end

    // ----------------------------------------------------------------
    // Chop: polarity swap per frame and two-frame average
    // ----------------------------------------------------------------
    logic            chop_phase_q;
    sinc3_pkg::sum_t frame_avg;
    sinc3_pkg::sum_t frame_val;
    sinc3_pkg::sum_t prev_val_q;
    sinc3_pkg::sum_t out_val;

    assign frame_avg   = acc_n >>> sinc3_pkg::AVG_SHIFT[avg_code];
    // The inverted orientation is turned back before averaging so offset cancels.
    assign frame_val   = chop_phase_q ? -frame_avg : frame_avg;
    assign out_val     = chop_enable ? ((frame_val + prev_val_q) >>> 1) : frame_val;
    assign chop_invert = chop_phase_q;

    always_ff @(posedge clk) begin
        if (rst || restart) begin
            chop_phase_q <= 1'b0;
        end else if (frame_end && chop_enable) begin
            chop_phase_q <= ~chop_phase_q;
        end
    end

    always_ff @(posedge clk) begin
        if (rst || restart) begin
            prev_val_q <= '0;
        end else if (frame_end) begin
            prev_val_q <= frame_val;
        end
    end

    // ----------------------------------------------------------------
    // Settling and step tracking
    // ----------------------------------------------------------------
    logic [1:0] frames_q;
    logic [1:0] frames_need;
    logic [1:0] step_left_q;
    logic       step_mid;

    // Chop doubles settling while the frame rate stays put.
    assign frames_need   = chop_enable ? sinc3_pkg::SETTLE_CHOP : sinc3_pkg::SETTLE_PLAIN;
    assign settling_time = frames_need;
    // A step on the frame boundary is aligned and spoils nothing.
    assign step_mid      = input_step && !frame_end && (idx_q != sinc3_pkg::IDX_RST || samp_cnt_q != '0);

    always_ff @(posedge clk) begin
        if (rst || restart) begin
            frames_q <= sinc3_pkg::FRAMES_RST;
        // Saturating at two keeps the sum in the settled test inside two bits.
        end else if (frame_end && frames_q != 2'h2) begin
            frames_q <= frames_q + 2'h1;
        end
    end

    // A new mid-frame step wins over the count-down of an older one.
    always_ff @(posedge clk) begin
        if (rst || restart) begin
            step_left_q <= 2'h0;
        end else if (step_mid) begin
            step_left_q <= frames_need;
        end else if (frame_end && step_left_q != 2'h0) begin
            step_left_q <= step_left_q - 2'h1;
        end
    end

    // ----------------------------------------------------------------
    // Result registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            result <= '0;
        end else if (frame_end && !restart) begin
            result <= sinc3_pkg::RES_W'(out_val);
        end
    end

    always_ff @(posedge clk) begin
        if (rst || restart) begin
            result_valid   <= 1'b0;
            result_settled <= 1'b0;
        end else begin
            result_valid   <= frame_end;
            result_settled <= frame_end && (frames_q + 2'h1 >= frames_need) && (step_left_q == 2'h0);
        end
    end

endmodule // fast_settle_sinc3_postfilter

// *** tb/fast_settle_monitor.sv ***
// Concurrent checks on the ports of the fast settling sinc3 path.
`timescale 1ns/1ps
module fast_settle_monitor (
    input wire logic                              clk,
    input wire logic                              rst,
    input wire logic                              mod_bit,
    input wire logic [sinc3_pkg::FW_W-1:0]        filter_word,
    input wire logic                              average_select_hi,
    input wire logic                              average_select_lo,
    input wire logic                              notch_60hz_enable,
    input wire logic                              chop_enable,
    input wire logic                              channel_change,
    input wire logic                              input_step,
    input wire logic signed [sinc3_pkg::RES_W-1:0] result,
    input wire logic                              result_valid,
    input wire logic                              result_settled,
    input wire logic                              chop_invert,
    input wire logic                              fast_mode,
    input wire logic [1:0]                        settling_time
);
    // ----------------------------------------------------------------
    // Cycles since the last result or restart
    // ----------------------------------------------------------------
    localparam int MIN_GAP = 38000;
    logic [13:0] cfg_now;
    logic [13:0] cfg_q;
    logic [31:0] since_q;
    assign cfg_now = {filter_word, average_select_hi, average_select_lo, notch_60hz_enable, chop_enable};
    always_ff @(posedge clk) begin
        cfg_q <= cfg_now;
    end
    always_ff @(posedge clk) begin
        if (rst || result_valid || channel_change || cfg_q != cfg_now) begin
            since_q <= 32'h00000000;
        end else if (since_q != 32'hFFFFFFFF) begin
            since_q <= since_q + 32'h00000001;
        end
    end

    // ----------------------------------------------------------------
    // Properties
    // ----------------------------------------------------------------
    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    chk_fast_mode_code: assert property (fast_mode == (average_select_hi | average_select_lo))
        else $error("fast mode does not follow the averaging code");
    chk_settle_periods: assert property (settling_time == (chop_enable ? sinc3_pkg::SETTLE_CHOP : sinc3_pkg::SETTLE_PLAIN))
        else $error("settling periods wrong for chop setting");
    chk_valid_pulse: assert property (result_valid |=> !result_valid)
        else $error("result valid held longer than one cycle");
    chk_result_holds: assert property (!$past(rst) && $changed(result) |-> result_valid)
        else $error("result changed without a result pulse");
    chk_reset_clears: assert property (disable iff (1'b0) rst |=> (result == '0 && !result_valid && !result_settled && !chop_invert))
        else $error("outputs not cleared by reset");
    chk_chop_steady: assert property (!$past(rst) && !$past(chop_enable) && !$past(chop_enable, 2)
        |-> $stable(chop_invert))
        else $error("input swap moved with chop off");
    chk_change_restart: assert property (channel_change |-> ##2 !result_valid [*8])
        else $error("result right after a channel change");
    chk_min_spacing: assert property (result_valid |-> since_q >= 32'(MIN_GAP))
        else $error("results closer than one sinc period");

    cov_settled: cover property (result_valid && result_settled);
    cov_change: cover property (channel_change);
    cov_chop_result: cover property (result_valid && chop_enable);
endmodule // fast_settle_monitor

bind fast_settle_sinc3_postfilter fast_settle_monitor fast_settle_monitor_i (
    .clk(clk), .rst(rst), .mod_bit(mod_bit), .filter_word(filter_word),
    .average_select_hi(average_select_hi), .average_select_lo(average_select_lo),
    .notch_60hz_enable(notch_60hz_enable), .chop_enable(chop_enable), .channel_change(channel_change),
    .input_step(input_step), .result(result), .result_valid(result_valid), .result_settled(result_settled),
    .chop_invert(chop_invert), .fast_mode(fast_mode), .settling_time(settling_time)
);

// *** tb/tb_fast_settle_sinc3_postfilter.sv ***
// Self-checking bench for the fast settling sinc3 path.
`timescale 1ns/1ps
module tb_fast_settle_sinc3_postfilter;
    // ----------------------------------------------------------------
    // Signals
    // ----------------------------------------------------------------
    localparam int FRAME = (sinc3_pkg::SINC_ORDER + 2 - 1) * sinc3_pkg::NOTCH_SCALE * sinc3_pkg::MCLK_DIV;
    localparam int SLACK = 1300;
    logic                               clk;
    logic                               rst;
    logic                               mod_bit;
    logic [sinc3_pkg::FW_W-1:0]         filter_word;
    logic                               average_select_hi;
    logic                               average_select_lo;
    logic                               notch_60hz_enable;
    logic                               chop_enable;
    logic                               channel_change;
    logic                               input_step;
    logic signed [sinc3_pkg::RES_W-1:0] result;
    logic                               result_valid;
    logic                               result_settled;
    logic                               chop_invert;
    logic                               fast_mode;
    logic [1:0]                         settling_time;
    int                                 miscompares;
    int                                 checks_done;
    int                                 n;
    logic [5:0]                         rows [0:7];

    fast_settle_sinc3_postfilter fast_settle_sinc3_postfilter_i (
        .clk(clk), .rst(rst), .mod_bit(mod_bit), .filter_word(filter_word),
        .average_select_hi(average_select_hi), .average_select_lo(average_select_lo),
        .notch_60hz_enable(notch_60hz_enable), .chop_enable(chop_enable), .channel_change(channel_change),
        .input_step(input_step), .result(result), .result_valid(result_valid), .result_settled(result_settled),
        .chop_invert(chop_invert), .fast_mode(fast_mode), .settling_time(settling_time)
    );

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic check(input string name, input logic [63:0] seen, input logic [63:0] expected);
        checks_done++;
        if (seen !== expected) begin
            miscompares++;
            $display("unexpected %s: expected %0h, seen %0h", name, expected, seen);
        end
    endtask

    task automatic results();
        $display("checks %0d, mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic tick();
        @(posedge clk);
        #1;
    endtask

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    initial begin
        #(5ns * 200000);
        miscompares++;
        results();
    end

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        // Row layout: {select hi, select lo, chop, fast mode, settling periods}.
        rows = '{6'h01, 6'h0A, 6'h15, 6'h1E, 6'h25, 6'h2E, 6'h35, 6'h3E};
        miscompares = 0;
        checks_done = 0;
        rst = 1'b1;
        mod_bit = 1'b1;
        // The fastest rate keeps the run short; the sinc4 advice above 1 kHz is for software.
        filter_word = 10'h001;
        average_select_hi = 1'b0;
        average_select_lo = 1'b0;
        notch_60hz_enable = 1'b0;
        chop_enable = 1'b0;
        channel_change = 1'b0;
        input_step = 1'b0;
        repeat (3) tick();
        rst = 1'b0;
        tick();
        check("result after reset", 64'(result), 64'h0);
        check("valid after reset", 64'(result_valid), 64'h0);
        check("settled after reset", 64'(result_settled), 64'h0);
        check("swap after reset", 64'(chop_invert), 64'h0);
        for (int i = 0; i < 8; i++) begin
            {average_select_hi, average_select_lo, chop_enable} = rows[i][5:3];
            tick();
            check("fast_mode", 64'(fast_mode), 64'(rows[i][2]));
            check("settling_time", 64'(settling_time), 64'(rows[i][1:0]));
        end
        // Averaging by two with word one, then a restart and a step on the boundary.
        average_select_hi = 1'b0;
        average_select_lo = 1'b1;
        chop_enable = 1'b0;
        tick();
        channel_change = 1'b1;
        tick();
        channel_change = 1'b0;
        input_step = 1'b1;
        tick();
        input_step = 1'b0;
        n = 2;
        while (result_valid !== 1'b1 && n < FRAME + SLACK) begin
            tick();
            n++;
        end
        check("frame early", 64'(n > FRAME - SLACK), 64'h1);
        check("frame late", 64'(n < FRAME + SLACK), 64'h1);
        check("settled", 64'(result_settled), 64'h1);
        check("result", 64'(result), 64'h0000000000040000);
        check("swap", 64'(chop_invert), 64'h0);
        tick();
        check("valid pulse", 64'(result_valid), 64'h0);
        check("result holds", 64'(result), 64'h0000000000040000);
        // A second reset in mid-run clears the held result and the flags.
        rst = 1'b1;
        repeat (3) tick();
        rst = 1'b0;
        tick();
        check("result after second reset", 64'(result), 64'h0);
        check("valid after second reset", 64'(result_valid), 64'h0);
        check("settled after second reset", 64'(result_settled), 64'h0);
        results();
    end
endmodule // tb_fast_settle_sinc3_postfilter
